// ===== verilog/rfa_reg.sv
// rfa_reg: one register of the field library with read mux and reserved-bit masking
// assumes: software strobes WR_I/RD_I for one cycle per access; state frozen while CE_I low
//
// Contract
// - read-clear field returns its value, then hardware clears it after the read
// - any write clears a write-any-to-clear register; reads show contents
// - writing 1 clears that bit only; writing 0 leaves it alone
// - writing back the read status clears only the bits reported
// - writing 1 sets that bit; writing 0 changes nothing; reads show value
// - write-only clear field clears on 1, ignores 0, reads carry no meaning
// - reserved bits read zero; software preserves them on read-modify-write
// - read/write field reads last written value or reset value
// - plain write-only register takes writes; its read value is undefined
`timescale 1ns/1ps
`default_nettype none
module rfa_reg
  import rfa_pkg::*;
#(
  parameter int WIDTH = RFA_DEF_WIDTH,
  parameter rfa_access_e ACCESS = RFA_RW,
  parameter logic [WIDTH-1:0] RESET_VAL = RFA_DEF_RESET[WIDTH-1:0],
  parameter logic [WIDTH-1:0] RSVD_MASK = RFA_DEF_RSVD[WIDTH-1:0]
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [WIDTH-1:0] WDATA_I,
  input wire logic [WIDTH-1:0] HW_SET_I,
  input wire logic HW_LOAD_I,
  input wire logic [WIDTH-1:0] HW_DATA_I,
  output logic [WIDTH-1:0] RDATA_O,
  output logic RVALID_O,
  output logic [WIDTH-1:0] VALUE_O
);

  if (WIDTH < 1 || WIDTH > RFA_MAX_WIDTH) begin : g_bad_width
    $error("rfa_reg: WIDTH out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // field storage

  logic [WIDTH-1:0] fval;
  logic [WIDTH-1:0] wmask;
  logic [WIDTH-1:0] set_m;
  logic [WIDTH-1:0] hw_m;

  // reserved bits never store; ro bits ignore the written value
  assign wmask = WDATA_I & ~RSVD_MASK;
  assign set_m = HW_SET_I & ~RSVD_MASK;
  assign hw_m = HW_DATA_I & ~RSVD_MASK;

  rfa_field #(
    .WIDTH(WIDTH),
    .ACCESS(ACCESS),
    .RESET_VAL(RESET_VAL & ~RSVD_MASK)
  ) u_field (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .wr_i(WR_I),
    .rd_i(RD_I & ~WR_I),
    .wdata_i(wmask),
    .hw_set_i(set_m),
    .hw_load_i(HW_LOAD_I),
    .hw_data_i(hw_m),
    .value_o(fval)
  );

  ////////////////////////////////////////////////////////////////////////
  // read path, registered

  function automatic logic [WIDTH-1:0] rd_view(input logic [WIDTH-1:0] v);
    logic [WIDTH-1:0] r;
    r = v & ~RSVD_MASK;
    if (ACCESS == RFA_W1C || ACCESS == RFA_WO) begin
      r = RFA_WO_READ[WIDTH-1:0];
    end
    return r;
  endfunction

  typedef struct packed {
    logic [WIDTH-1:0] rdata;
    logic rvalid;
    logic [WIDTH-1:0] value;
  } rfa_state_s;

  rfa_state_s s_q;
  rfa_state_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.rvalid = RD_I & ~WR_I;
    if (RD_I && !WR_I) begin
      // value before the read side effect takes hold
      s_d.rdata = rd_view(fval);
    end
    s_d.value = fval;
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      s_q <= '0;
    end else if (CE_I) begin
      s_q <= s_d;
    end
  end

  assign RDATA_O = s_q.rdata;
  assign RVALID_O = s_q.rvalid;
  assign VALUE_O = s_q.value;

endmodule
`default_nettype wire

// ===== verilog/rfa_pkg.sv
// rfa_pkg: access-type codes, widths and reset defaults for the register-field library
// assumes: included before every rfa module
package rfa_pkg;

  // access types of one field
  typedef enum logic [2:0] {
    RFA_RO   = 3'h0,
    RFA_RW   = 3'h1,
    RFA_RC   = 3'h2,
    RFA_RWC  = 3'h3,
    RFA_RW1C = 3'h4,
    RFA_RW1S = 3'h5,
    RFA_W1C  = 3'h6,
    RFA_WO   = 3'h7
  } rfa_access_e;

  localparam int RFA_DEF_WIDTH = 32;
  localparam int RFA_MAX_WIDTH = 64;
  localparam logic [RFA_MAX_WIDTH-1:0] RFA_DEF_RESET = '0;
  localparam logic [RFA_MAX_WIDTH-1:0] RFA_DEF_RSVD = '0;
  // value shown on a read of a write-only field
  localparam logic [RFA_MAX_WIDTH-1:0] RFA_WO_READ = '0;

endpackage

// ===== verilog/rfa_field.sv
// rfa_field: storage and update of one register under a chosen access type
// assumes: one write or read strobe per cycle; hw set bits sampled with the clock
`timescale 1ns/1ps
`default_nettype none
module rfa_field
  import rfa_pkg::*;
#(
  parameter int WIDTH = RFA_DEF_WIDTH,
  parameter rfa_access_e ACCESS = RFA_RW,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [WIDTH-1:0] hw_set_i,
  input wire logic hw_load_i,
  input wire logic [WIDTH-1:0] hw_data_i,
  output logic [WIDTH-1:0] value_o
);

  typedef struct packed {
    logic [WIDTH-1:0] val;
  } rfa_fstate_s;

  rfa_fstate_s s_q;
  rfa_fstate_s s_d;

  assign value_o = s_q.val;

  always_comb begin
    s_d = s_q;
    case (ACCESS)
      RFA_RO: begin
        if (hw_load_i) begin
          s_d.val = hw_data_i;
        end
      end
      RFA_RW, RFA_WO: begin
        if (wr_i) begin
          s_d.val = wdata_i;
        end
      end
      RFA_RC: begin
        if (rd_i) begin
          s_d.val = '0;
        end
        s_d.val = s_d.val | hw_set_i;
      end
      RFA_RWC: begin
        if (wr_i) begin
          s_d.val = '0;
        end
        s_d.val = s_d.val | hw_set_i;
      end
      RFA_RW1C, RFA_W1C: begin
        if (wr_i) begin
          s_d.val = s_q.val & ~wdata_i;
        end
        s_d.val = s_d.val | hw_set_i;
      end
      RFA_RW1S: begin
        if (wr_i) begin
          s_d.val = s_q.val | wdata_i;
        end
      end
      default: begin
        s_d = s_q;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.val <= RESET_VAL;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// ===== bench/rfa_reg_sva.sv
// rfa_reg_sva: checks on a write-one-to-clear register
// assumes CE_I held high
`timescale 1ns/1ps
`default_nettype none
module rfa_reg_sva #(parameter int WIDTH = 8, parameter logic [WIDTH-1:0] RSVD_MASK = '0) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [WIDTH-1:0] WDATA_I,
  input wire logic [WIDTH-1:0] HW_SET_I,
  input wire logic [WIDTH-1:0] RDATA_O,
  input wire logic RVALID_O,
  input wire logic [WIDTH-1:0] VALUE_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  rsvd_read_a: assert property ((RDATA_O & RSVD_MASK) == '0) else $error("rsvd rd");
  rsvd_value_a: assert property ((VALUE_O & RSVD_MASK) == '0) else $error("rsvd val");
  clr_bits_a: assert property (WR_I |-> ##2 ((VALUE_O & $past(WDATA_I, 2) & ~$past(HW_SET_I, 2)) == '0))
    else $error("clr");
  keep_bits_a: assert property (WR_I |=> ##1 ((VALUE_O & ~$past(WDATA_I, 2)) ==
    (($past(VALUE_O) | $past(HW_SET_I, 2)) & ~$past(WDATA_I, 2) & ~RSVD_MASK))) else $error("keep");
  hw_wins_a: assert property (HW_SET_I != '0 |-> ##2
    ((VALUE_O & $past(HW_SET_I, 2)) == ($past(HW_SET_I, 2) & ~RSVD_MASK))) else $error("hw");
  read_data_a: assert property (RD_I && !WR_I |=> RVALID_O && RDATA_O == VALUE_O) else $error("rd");
  no_valid_a: assert property (!(RD_I && !WR_I) |=> !RVALID_O) else $error("rvalid");
  rdata_hold_a: assert property (!RVALID_O |-> $stable(RDATA_O)) else $error("hold");
  cover property (RVALID_O);
  cover property (WR_I && (HW_SET_I & WDATA_I) != '0);
  cover property (WR_I ##1 RD_I);
endmodule
bind rfa_reg rfa_reg_sva #(.WIDTH(WIDTH), .RSVD_MASK(RSVD_MASK)) sva (.MCLK_I(MCLK_I), .RST_I(RST_I),
  .WR_I(WR_I), .RD_I(RD_I), .WDATA_I(WDATA_I), .HW_SET_I(HW_SET_I), .RDATA_O(RDATA_O),
  .RVALID_O(RVALID_O), .VALUE_O(VALUE_O));
`default_nettype wire

// ===== bench/rfa_sw_model.sv
// rfa_sw_model: software side issuing single reads and writes
// assumes tasks entered just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module rfa_sw_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  initial begin
    wr_o = 0;
    rd_o = 0;
    wdata_o = 8'hA5;
  end
  task automatic write(input logic [7:0] d);
    wr_o = 1;
    wdata_o = d;
    @(posedge clk_i);
    #1 wr_o = 0;
    wdata_o = ~d;
  endtask
  task automatic read(output logic [7:0] d);
    rd_o = 1;
    @(posedge clk_i);
    #1 rd_o = 0;
    @(posedge clk_i);
    #1 d = rdata_i;
  endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// testbench: random event, read, write-back on one write-one-to-clear register
// assumes top bit reserved
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rfa_pkg::*;
  logic clk = 0, rst = 1, wr, rd, rv;
  logic [7:0] hs = 0, rdat, val, wd, d, w, m = 0, hd = 0;
  logic hl = 0;
  logic [31:0] s = 32'h6F8B447D;
  int err_count = 0, checked = 0;
  always #25 clk = ~clk;
  rfa_reg #(.WIDTH(8), .ACCESS(RFA_RW1C), .RESET_VAL(8'h00), .RSVD_MASK(8'h80)) dut (.MCLK_I(clk),
    .RST_I(rst), .CE_I(1'b1), .WR_I(wr), .RD_I(rd), .WDATA_I(wd), .HW_SET_I(hs), .HW_LOAD_I(hl),
    .HW_DATA_I(hd), .RDATA_O(rdat), .RVALID_O(rv), .VALUE_O(val));
  rfa_sw_model sw (.clk_i(clk), .rdata_i(rdat), .wr_o(wr), .rd_o(rd), .wdata_o(wd));
  function automatic logic [7:0] nxt(input logic [7:0] o, input logic [7:0] c, input logic [7:0] h);
    return ((o & ~c) | h) & 8'h7F;
  endfunction
  task automatic rnd();
    s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (e !== g) begin
      $display("ERROR %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #50000 err_count++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 0;
    for (int i = 0; i < 20; i++) begin
      rnd();
      hs = (i == 0) ? 8'hFF : s[7:0];
      // load path must be ignored by a clear-type field
      hl = s[24];
      hd = s[31:24];
      m = nxt(m, 8'h00, hs);
      @(posedge clk);
      #1 hs = 0;
      sw.read(d);
      chk("rdata", m, d);
      chk("value", m, val);
      rnd();
      w = (i == 0) ? 8'hFF : d & s[15:8];
      hs = s[23:16];
      m = nxt(m, w, hs);
      sw.write(w);
      hs = 0;
      sw.read(d);
      chk("rdata", m, d);
      chk("value", m, val);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
